// ### hdl/pllcr_bus_if.sv
/*
 * Internal register access path between the serial port engine and the
 * register bank. Assumes both ends sit on ref_clk.
 */
`timescale 1ns/1ps
interface pllcr_bus_if;
    logic wr_stb;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport port
    (
        output wr_stb,
        output addr,
        output wdata,
        input rdata
    );
    modport regs
    (
        input wr_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface

// ### hdl/pllcr_pkg.sv
/*
 * Constants for the PLL control register bank: serial port framing,
 * register addresses, field positions and values after reset.
 * Assumes a thirteen-bit address space of eight-bit registers reached over the serial control port.
 */
// What this block does
// - Bit 7 picks detector polarity, default positive
// - Bits 6:4 pump current, 0.6-4.8 mA, default 111
// - Bits 3:2 pump mode, default normal 11
// - Fourteen-bit reference divider split, resets to one
// - Six-bit swallow, thirteen-bit main counter, zero default
// - Main counter upper five bits sit in 4:0
// - Bit 7 forces pump output to midpoint
// - Bit 6 holds reference divider reset, sticky
// - Global update bit copies buffers, then self-clears
// - Readback shows buffers unless active copies selected
package pllcr_pkg;
    localparam int ADDR_W = 13;
    localparam int INSTR_BITS = 16;
    localparam logic [4:0] INSTR_LAST = 5'h0F;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam int RW_BIT = 14;

    localparam logic [12:0] ADDR_READBACK = 13'h0004;
    localparam logic [12:0] ADDR_DET_PUMP = 13'h0010;
    localparam logic [12:0] ADDR_REF_LO = 13'h0011;
    localparam logic [12:0] ADDR_REF_HI = 13'h0012;
    localparam logic [12:0] ADDR_SWALLOW = 13'h0013;
    localparam logic [12:0] ADDR_MAIN_LO = 13'h0014;
    localparam logic [12:0] ADDR_MAIN_HI = 13'h0015;
    localparam logic [12:0] ADDR_DIV_MISC = 13'h0016;
    localparam logic [12:0] ADDR_UPDATE = 13'h0232;

    localparam int POL_BIT = 7;
    localparam int CUR_LSB = 4;
    localparam int MODE_LSB = 2;
    localparam int MIDPT_BIT = 7;
    localparam int REFRST_BIT = 6;
    localparam int UPDATE_BIT = 0;
    localparam int READBACK_BIT = 0;

    localparam logic RST_POL = 1'b0;
    localparam logic [2:0] RST_CUR = 3'h7;
    localparam logic [1:0] RST_MODE = 2'h3;
    localparam logic [7:0] RST_REF_LO = 8'h01;
    localparam logic [5:0] RST_REF_HI = 6'h00;
    localparam logic [5:0] RST_SWALLOW = 6'h00;
    localparam logic [7:0] RST_MAIN_LO = 8'h00;
    localparam logic [4:0] RST_MAIN_HI = 5'h00;
    localparam logic RST_MIDPT = 1'b0;
    localparam logic RST_REFRST = 1'b0;
endpackage

// ### hdl/pllcr_spi_port.sv
/*
 * Serial control port engine: 16-bit instruction (read flag, two length
 * bits, 13-bit address), then data bytes MSB first with the address
 * decrementing per byte until chip select rises.
 * Assumes sclk, cs_n and sdio are synchronous to ref_clk and that sclk runs
 * well below a quarter of ref_clk.
 */
`timescale 1ns/1ps
module pllcr_spi_port
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio,
    output logic sdo,
    output logic sdo_oe,
    pllcr_bus_if.port bus
);
    logic sclk_r;
    logic instr_done_r;
    logic rd_r;
    logic [4:0] cnt_r;
    logic [14:0] shift_r;
    logic [7:0] out_sh_r;
    logic [12:0] addr_r;
    logic wr_stb_r;
    logic byte_end_r;
    logic [7:0] wdata_r;
    logic rise;
    logic fall;

    assign rise = sclk & ~sclk_r & ~cs_n;
    assign fall = ~sclk & sclk_r & ~cs_n;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            sclk_r <= 1'b0;
        else
            sclk_r <= sclk;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_done_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 5'h00;
            shift_r <= 15'h0000;
            addr_r <= 13'h0000;
            wr_stb_r <= 1'b0;
            byte_end_r <= 1'b0;
            wdata_r <= 8'h00;
        end
        else
        begin
            wr_stb_r <= 1'b0;
            byte_end_r <= 1'b0;
            // Step the address one cycle after the strobe so the write lands at the old address;
            // the next read byte still sees the new one because sclk stays high for two cycles
            if (byte_end_r)
                addr_r <= addr_r - 13'h0001;
            if (cs_n)
            begin
                instr_done_r <= 1'b0;
                cnt_r <= 5'h00;
            end
            else if (rise)
            begin
                shift_r <= {shift_r[13:0], sdio};
                cnt_r <= cnt_r + 5'h01;
                if (!instr_done_r && cnt_r == pllcr_pkg::INSTR_LAST)
                begin
                    // Length bits are ignored: streaming runs until chip select rises
                    instr_done_r <= 1'b1;
                    rd_r <= shift_r[pllcr_pkg::RW_BIT];
                    addr_r <= {shift_r[11:0], sdio};
                    cnt_r <= 5'h00;
                end
                else if (instr_done_r && cnt_r == pllcr_pkg::BYTE_LAST)
                begin
                    cnt_r <= 5'h00;
                    byte_end_r <= 1'b1;
                    wr_stb_r <= ~rd_r;
                    wdata_r <= {shift_r[6:0], sdio};
                end
            end
        end
    end

    // Read data leaves on the falling edge so the master samples it on the next rise
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            out_sh_r <= 8'h00;
        end
        else if (cs_n)
            sdo_oe <= 1'b0;
        else if (fall && instr_done_r && rd_r)
        begin
            sdo_oe <= 1'b1;
            if (cnt_r == 5'h00)
            begin
                sdo <= bus.rdata[7];
                out_sh_r <= {bus.rdata[6:0], 1'b0};
            end
            else
            begin
                sdo <= out_sh_r[7];
                out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    assign bus.wr_stb = wr_stb_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
endmodule

// ### hdl/pllcr_top.sv
/*
 * PLL control register bank: buffered registers written over the serial
 * port, working copies loaded by the global update bit and driven to the
 * analog PLL core, and readback of either bank.
 * Assumes the serial pins are synchronous to ref_clk.
 */
`timescale 1ns/1ps
module pllcr_top
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio,
    output logic sdo,
    output logic sdo_oe,
    output logic detector_polarity,
    output logic [2:0] pump_current_field,
    output logic [1:0] pump_mode_field,
    output logic [13:0] ref_div,
    output logic [5:0] swallow_count,
    output logic [12:0] main_count,
    output logic pump_midpoint_force,
    output logic ref_div_reset
);
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    pllcr_bus_if bus();

    pllcr_spi_port u_port
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n_r),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdio(sdio),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .bus(bus)
    );

    // Buffer bank written by software
    logic pol_r;
    logic [2:0] cur_r;
    logic [1:0] mode_r;
    logic [7:0] ref_lo_r;
    logic [5:0] ref_hi_r;
    logic [5:0] swallow_r;
    logic [7:0] main_lo_r;
    logic [4:0] main_hi_r;
    logic midpt_r;
    logic refrst_r;
    logic readback_sel_r;
    logic update_r;
    logic [7:0] rdata_nxt;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pol_r <= pllcr_pkg::RST_POL;
            cur_r <= pllcr_pkg::RST_CUR;
            mode_r <= pllcr_pkg::RST_MODE;
            ref_lo_r <= pllcr_pkg::RST_REF_LO;
            ref_hi_r <= pllcr_pkg::RST_REF_HI;
            swallow_r <= pllcr_pkg::RST_SWALLOW;
            main_lo_r <= pllcr_pkg::RST_MAIN_LO;
            main_hi_r <= pllcr_pkg::RST_MAIN_HI;
            midpt_r <= pllcr_pkg::RST_MIDPT;
            refrst_r <= pllcr_pkg::RST_REFRST;
            readback_sel_r <= 1'b0;
        end
        else if (bus.wr_stb)
        begin
            case (bus.addr)
                pllcr_pkg::ADDR_DET_PUMP:
                begin
                    pol_r <= bus.wdata[pllcr_pkg::POL_BIT];
                    cur_r <= bus.wdata[pllcr_pkg::CUR_LSB +: 3];
                    mode_r <= bus.wdata[pllcr_pkg::MODE_LSB +: 2];
                end
                pllcr_pkg::ADDR_REF_LO: ref_lo_r <= bus.wdata;
                pllcr_pkg::ADDR_REF_HI: ref_hi_r <= bus.wdata[5:0];
                pllcr_pkg::ADDR_SWALLOW: swallow_r <= bus.wdata[5:0];
                pllcr_pkg::ADDR_MAIN_LO: main_lo_r <= bus.wdata;
                pllcr_pkg::ADDR_MAIN_HI: main_hi_r <= bus.wdata[4:0];
                pllcr_pkg::ADDR_DIV_MISC:
                begin
                    midpt_r <= bus.wdata[pllcr_pkg::MIDPT_BIT];
                    refrst_r <= bus.wdata[pllcr_pkg::REFRST_BIT];
                end
                pllcr_pkg::ADDR_READBACK: readback_sel_r <= bus.wdata[pllcr_pkg::READBACK_BIT];
                default: ;
            endcase
        end
    end

    // One-cycle request; the transfer happens on the next edge and the bit drops
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            update_r <= 1'b0;
        else
            update_r <= bus.wr_stb && bus.addr == pllcr_pkg::ADDR_UPDATE
                        && bus.wdata[pllcr_pkg::UPDATE_BIT];
    end

    // Working copies: change only on update, so a multi-byte divider never glitches
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            detector_polarity <= pllcr_pkg::RST_POL;
            pump_current_field <= pllcr_pkg::RST_CUR;
            pump_mode_field <= pllcr_pkg::RST_MODE;
            ref_div <= {pllcr_pkg::RST_REF_HI, pllcr_pkg::RST_REF_LO};
            swallow_count <= pllcr_pkg::RST_SWALLOW;
            main_count <= {pllcr_pkg::RST_MAIN_HI, pllcr_pkg::RST_MAIN_LO};
            pump_midpoint_force <= pllcr_pkg::RST_MIDPT;
            ref_div_reset <= pllcr_pkg::RST_REFRST;
        end
        else if (update_r)
        begin
            detector_polarity <= pol_r;
            pump_current_field <= cur_r;
            pump_mode_field <= mode_r;
            ref_div <= {ref_hi_r, ref_lo_r};
            swallow_count <= swallow_r;
            main_count <= {main_hi_r, main_lo_r};
            pump_midpoint_force <= midpt_r;
            ref_div_reset <= refrst_r;
        end
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        case (bus.addr)
            pllcr_pkg::ADDR_DET_PUMP:
                rdata_nxt = readback_sel_r ? {detector_polarity, pump_current_field, pump_mode_field, 2'b00}
                                           : {pol_r, cur_r, mode_r, 2'b00};
            pllcr_pkg::ADDR_REF_LO: rdata_nxt = readback_sel_r ? ref_div[7:0] : ref_lo_r;
            pllcr_pkg::ADDR_REF_HI: rdata_nxt = {2'b00, readback_sel_r ? ref_div[13:8] : ref_hi_r};
            pllcr_pkg::ADDR_SWALLOW: rdata_nxt = {2'b00, readback_sel_r ? swallow_count : swallow_r};
            pllcr_pkg::ADDR_MAIN_LO: rdata_nxt = readback_sel_r ? main_count[7:0] : main_lo_r;
            pllcr_pkg::ADDR_MAIN_HI: rdata_nxt = {3'b000, readback_sel_r ? main_count[12:8] : main_hi_r};
            pllcr_pkg::ADDR_DIV_MISC:
                rdata_nxt = readback_sel_r ? {pump_midpoint_force, ref_div_reset, 6'h00}
                                           : {midpt_r, refrst_r, 6'h00};
            pllcr_pkg::ADDR_READBACK: rdata_nxt = {7'h00, readback_sel_r};
            pllcr_pkg::ADDR_UPDATE: rdata_nxt = {7'h00, update_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    assign bus.rdata = rdata_nxt;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n_r);

    AST_POL_XFER: assert property (update_r |=> detector_polarity == $past(pol_r))
        else $error("Polarity not loaded on update");
    AST_CUR_XFER: assert property (update_r |=> pump_current_field == $past(cur_r))
        else $error("Pump current not loaded on update");
    AST_MODE_WRITE: assert property (bus.wr_stb && bus.addr == pllcr_pkg::ADDR_DET_PUMP
                                     |=> mode_r == $past(bus.wdata[3:2]))
        else $error("Pump mode buffer not written");
    AST_REF_XFER: assert property (update_r |=> ref_div == {$past(ref_hi_r), $past(ref_lo_r)})
        else $error("Reference divider not loaded on update");
    AST_SWALLOW_XFER: assert property (update_r |=> swallow_count == $past(swallow_r))
        else $error("Swallow counter not loaded on update");
    AST_MAIN_JOIN: assert property (update_r |=> main_count[12:8] == $past(main_hi_r)
                                     && main_count[7:0] == $past(main_lo_r))
        else $error("Main counter halves misjoined");
    AST_MIDPT_XFER: assert property (update_r |=> pump_midpoint_force == $past(midpt_r))
        else $error("Midpoint force not loaded on update");
    AST_REFRST_STICKY: assert property (refrst_r && !(bus.wr_stb && bus.addr == pllcr_pkg::ADDR_DIV_MISC)
                                        |=> refrst_r)
        else $error("Reference divider reset cleared itself");
    AST_UPDATE_SELFCLR: assert property (update_r |=> !update_r)
        else $error("Update bit did not self-clear");
    AST_ACTIVE_HOLD: assert property (!update_r |=> $stable(ref_div) && $stable(main_count)
                                      && $stable(swallow_count))
        else $error("Working copy changed without update");
    AST_READBACK_SEL: assert property (bus.addr == pllcr_pkg::ADDR_SWALLOW
                                       |-> bus.rdata[5:0] == (readback_sel_r ? swallow_count : swallow_r))
        else $error("Readback bank select wrong");
    AST_UNUSED_ZERO: assert property (bus.addr == pllcr_pkg::ADDR_MAIN_HI |-> bus.rdata[7:5] == 3'b000)
        else $error("Unused main counter bits read nonzero");

    // Buffer writes and update transfers: each field lands in its own bits, spare read bits stay at zero
    AST_POL_WRITE: assert property (bus.wr_stb && bus.addr == pllcr_pkg::ADDR_DET_PUMP
                                    |=> pol_r == $past(bus.wdata[7]))
        else $error("Polarity buffer not written");
    AST_CUR_WRITE: assert property (bus.wr_stb && bus.addr == pllcr_pkg::ADDR_DET_PUMP
                                    |=> cur_r == $past(bus.wdata[6:4]))
        else $error("Pump current buffer not written");
    AST_MODE_XFER: assert property (update_r |=> pump_mode_field == $past(mode_r))
        else $error("Pump mode not loaded on update");
    AST_REFRST_XFER: assert property (update_r |=> ref_div_reset == $past(refrst_r))
        else $error("Reference divider reset not loaded on update");
    AST_REFHI_UNUSED: assert property (bus.addr == pllcr_pkg::ADDR_REF_HI |-> bus.rdata[7:6] == 2'b00)
        else $error("Unused reference divider bits read nonzero");
    AST_SWALLOW_UNUSED: assert property (bus.addr == pllcr_pkg::ADDR_SWALLOW |-> bus.rdata[7:6] == 2'b00)
        else $error("Unused swallow counter bits read nonzero");
    AST_DIVMISC_UNUSED: assert property (bus.addr == pllcr_pkg::ADDR_DIV_MISC |-> bus.rdata[5:0] == 6'h00)
        else $error("Unused divider control bits read nonzero");
endmodule

// ### tb/test_pll_control_registers.sv
/*
 * Self-checking bench for the PLL control register bank: serial port reads
 * and writes, global update transfer, readback select and the static outputs.
 * Assumes the package, interface and design modules under hdl/ compile first.
 */
`timescale 1ns/1ps
module test_pll_control_registers;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic sdio = 1'b0;
    logic sdo;
    logic sdo_oe;
    logic detector_polarity;
    logic [2:0] pump_current_field;
    logic [1:0] pump_mode_field;
    logic [13:0] ref_div;
    logic [5:0] swallow_count;
    logic [12:0] main_count;
    logic pump_midpoint_force;
    logic ref_div_reset;
    logic [7:0] sh = 8'h00;
    logic [7:0] v;
    logic oe_seen = 1'b0;
    int fail_count = 0;
    int num_checks = 0;

    pllcr_top i_dut
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdio(sdio),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .detector_polarity(detector_polarity),
        .pump_current_field(pump_current_field),
        .pump_mode_field(pump_mode_field),
        .ref_div(ref_div),
        .swallow_count(swallow_count),
        .main_count(main_count),
        .pump_midpoint_force(pump_midpoint_force),
        .ref_div_reset(ref_div_reset)
    );

    always #20 ref_clk = ~ref_clk;

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // sclk held two ref_clk cycles per level so the port sees every edge
    task automatic tick(input logic b);
        sdio = b;
        sclk = 1'b0;
        repeat (2) @(negedge ref_clk);
        sh = {sh[6:0], sdo};
        sclk = 1'b1;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] d);
        logic [15:0] ins;
        ins = {r, 2'b00, a};
        @(negedge ref_clk);
        cs_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        for (int i = 15; i >= 0; i--)
            tick(ins[i]);
        for (int i = 7; i >= 0; i--)
            tick(d[i]);
        oe_seen = sdo_oe;
        sclk = 1'b0;
        repeat (2) @(negedge ref_clk);
        cs_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        xfer(1'b0, a, d);
    endtask

    task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
        xfer(1'b1, a, 8'h00);
        chk({8'h00, sh}, {8'h00, exp});
        chk({15'h0000, oe_seen}, 16'h0001);
    endtask

    task automatic upd;
        wr(pllcr_pkg::ADDR_UPDATE, 8'h01);
        repeat (2) @(negedge ref_clk);
    endtask

    // A hang counts as one mismatch and still reaches the verdict
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        chk(16'h0001, 16'h0000);
        end_of_test();
    end

    initial
    begin
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({10'h000, detector_polarity, pump_current_field, pump_mode_field}, 16'h001F);
        chk({2'b00, ref_div}, 16'h0001);
        chk({3'b000, main_count}, 16'h0000);
        chk({10'h000, swallow_count}, 16'h0000);
        chk({14'h0000, pump_midpoint_force, ref_div_reset}, 16'h0000);
        rdc(pllcr_pkg::ADDR_DET_PUMP, 8'h7C);
        rdc(pllcr_pkg::ADDR_REF_LO, 8'h01);
        rdc(pllcr_pkg::ADDR_REF_HI, 8'h00);
        rdc(pllcr_pkg::ADDR_MAIN_HI, 8'h00);
        // Each polarity, current and mode code gets its own update
        for (int i = 0; i < 8; i++)
        begin
            v = {i[0], i[2:0], i[1:0], 2'b00};
            wr(pllcr_pkg::ADDR_DET_PUMP, v);
            upd();
            chk({10'h000, detector_polarity, pump_current_field, pump_mode_field}, {10'h000, v[7:2]});
        end
        wr(pllcr_pkg::ADDR_REF_LO, 8'hA5);
        wr(pllcr_pkg::ADDR_REF_HI, 8'hFF);
        wr(pllcr_pkg::ADDR_SWALLOW, 8'hFF);
        wr(pllcr_pkg::ADDR_MAIN_LO, 8'h5A);
        wr(pllcr_pkg::ADDR_MAIN_HI, 8'hFF);
        wr(pllcr_pkg::ADDR_DIV_MISC, 8'hFF);
        rdc(pllcr_pkg::ADDR_REF_HI, 8'h3F);
        rdc(pllcr_pkg::ADDR_SWALLOW, 8'h3F);
        rdc(pllcr_pkg::ADDR_MAIN_HI, 8'h1F);
        rdc(pllcr_pkg::ADDR_DIV_MISC, 8'hC0);
        chk({2'b00, ref_div}, 16'h0001);
        chk({14'h0000, pump_midpoint_force, ref_div_reset}, 16'h0000);
        wr(pllcr_pkg::ADDR_READBACK, 8'h01);
        rdc(pllcr_pkg::ADDR_REF_LO, 8'h01);
        rdc(pllcr_pkg::ADDR_DIV_MISC, 8'h00);
        upd();
        chk({2'b00, ref_div}, 16'h3FA5);
        chk({10'h000, swallow_count}, 16'h003F);
        chk({3'b000, main_count}, 16'h1F5A);
        chk({14'h0000, pump_midpoint_force, ref_div_reset}, 16'h0003);
        rdc(pllcr_pkg::ADDR_REF_LO, 8'hA5);
        rdc(pllcr_pkg::ADDR_UPDATE, 8'h00);
        wr(pllcr_pkg::ADDR_READBACK, 8'h00);
        wr(pllcr_pkg::ADDR_DIV_MISC, 8'h40);
        upd();
        chk({14'h0000, pump_midpoint_force, ref_div_reset}, 16'h0001);
        wr(pllcr_pkg::ADDR_REF_LO, 8'h3C);
        rdc(pllcr_pkg::ADDR_REF_LO, 8'h3C);
        chk({2'b00, ref_div}, 16'h3FA5);
        wr(pllcr_pkg::ADDR_DIV_MISC, 8'h00);
        upd();
        chk({14'h0000, pump_midpoint_force, ref_div_reset}, 16'h0000);
        chk({2'b00, ref_div}, 16'h3F3C);
        rdc(13'h0017, 8'h00);
        chk({15'h0000, sdo_oe}, 16'h0000);
        end_of_test();
    end
endmodule
